/* File: logic/uldr_bus_edges.sv */
// serial bus edge and start/stop condition detector
`timescale 1ns/1ps
module uldr_bus_edges
  import uldr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_rise_out,
  output logic scl_fall_out,
  output logic start_out,
  output logic stop_out
);
  typedef struct packed {
    logic scl;
    logic sda;
  } uldr_edge_state_t;

  uldr_edge_state_t state_reg;
  uldr_edge_state_t state_next;

  // previous line levels; idle bus is high on both lines
  always_comb begin
    state_next.scl = scl_in;
    state_next.sda = sda_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= '{scl: 1'b1, sda: 1'b1};
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  // pulses last one enabled cycle; data changes with clock high mark frames
  assign scl_rise_out = ce_in & scl_in & ~state_reg.scl;
  assign scl_fall_out = ce_in & ~scl_in & state_reg.scl;
  assign start_out = ce_in & scl_in & state_reg.scl & state_reg.sda & ~sda_in;
  assign stop_out = ce_in & scl_in & state_reg.scl & ~state_reg.sda & sda_in;
endmodule : uldr_bus_edges

/* File: logic/uldr_line_driver_regs.sv */
// line driver control, minus-line result and identity registers on a
// serial-bus target port
`timescale 1ns/1ps
module uldr_line_driver_regs
  import uldr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic adc_valid_in,
  input wire logic [15:0] adc_data_in,
  output logic [2:0] plus_line_drive_level_out,
  output logic [2:0] minus_line_drive_level_out,
  output logic [15:0] minus_line_adc_result_out
);
  typedef struct packed {
    uldr_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic ptr_pending;
    logic drv;
    logic [2:0] plus_lvl;
    logic [2:0] minus_lvl;
    logic [15:0] adc;
    logic [7:0] adc_lo_snap;
  } uldr_state_all_t;

  uldr_state_all_t state_reg;
  uldr_state_all_t state_next;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // clamp a converter sample into the documented span
  function automatic logic [15:0] uldr_clamp(input logic [15:0] v);
    uldr_clamp = (v > ULDR_ADC_MAX_MV) ? ULDR_ADC_MAX_MV : v;
  endfunction : uldr_clamp

  // read data for one register offset; unmapped offsets read zero
  function automatic logic [7:0] uldr_read(input logic [7:0] ofs,
                                          input uldr_state_all_t s);
    logic [7:0] d;
    d = 8'h00;
    case (ofs)
      ULDR_OFS_MINUS_ADC_HI: d = s.adc[15:8];
      ULDR_OFS_MINUS_ADC_LO: d = s.adc_lo_snap;
      ULDR_OFS_LINE_DRIVER: begin
        d[ULDR_PLUS_MSB:ULDR_PLUS_LSB] = s.plus_lvl;
        d[ULDR_MINUS_MSB:ULDR_MINUS_LSB] = s.minus_lvl;
      end
      ULDR_OFS_PART_REV: begin
        d[ULDR_PART_MSB:ULDR_PART_LSB] = ULDR_PART_CODE;
        d[ULDR_REV_MSB:ULDR_REV_LSB] = ULDR_REV_CODE;
      end
      default: d = 8'h00;
    endcase
    uldr_read = d;
  endfunction : uldr_read

  uldr_bus_edges uldr_bus_edges_inst (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(bus_start),
    .stop_out(bus_stop)
  );

  // protocol engine and register updates
  always_comb begin
    state_next = state_reg;
    // converter results land whenever the engine offers one with the clock enable high
    if (adc_valid_in) begin
      state_next.adc = uldr_clamp(adc_data_in);
    end
    if (bus_stop) begin
      state_next.st = ULDR_IDLE;
      state_next.drv = 1'b0;
    end else if (bus_start) begin
      // repeated start keeps the pointer so a read can follow a write
      state_next.st = ULDR_ADDR;
      state_next.bitcnt = 4'h0;
      state_next.drv = 1'b0;
    end else begin
      case (state_reg.st)
        ULDR_IDLE: begin
          state_next.drv = 1'b0;
        end
        ULDR_ADDR: begin
          if (scl_rise) begin
            state_next.shreg = {state_reg.shreg[6:0], sda_in};
            state_next.bitcnt = state_reg.bitcnt + 4'h1;
          end else if (scl_fall && state_reg.bitcnt == ULDR_BYTE_BITS) begin
            if (state_reg.shreg[7:1] == ULDR_TARGET_ADDR) begin
              state_next.st = ULDR_ACK_ADDR;
              state_next.drv = 1'b1;
            end else begin
              state_next.st = ULDR_IDLE;
            end
          end
        end
        ULDR_ACK_ADDR: begin
          if (scl_fall) begin
            state_next.bitcnt = 4'h0;
            if (state_reg.shreg[0]) begin
              state_next.shreg = uldr_read(state_reg.ptr, state_reg);
              state_next.drv = ~state_next.shreg[7];
              state_next.ptr = state_reg.ptr + 8'h01;
              state_next.st = ULDR_READ;
              // low byte is frozen when the high byte goes out
              if (state_reg.ptr == ULDR_OFS_MINUS_ADC_HI) begin
                state_next.adc_lo_snap = state_reg.adc[7:0];
              end
            end else begin
              state_next.drv = 1'b0;
              state_next.ptr_pending = 1'b1;
              state_next.st = ULDR_WRITE;
            end
          end
        end
        ULDR_WRITE: begin
          if (scl_rise) begin
            state_next.shreg = {state_reg.shreg[6:0], sda_in};
            state_next.bitcnt = state_reg.bitcnt + 4'h1;
          end else if (scl_fall && state_reg.bitcnt == ULDR_BYTE_BITS) begin
            state_next.drv = 1'b1;
            state_next.st = ULDR_ACK_WR;
            if (state_reg.ptr_pending) begin
              state_next.ptr = state_reg.shreg;
              state_next.ptr_pending = 1'b0;
            end else begin
              // only the drive fields take writes; others are read-only
              if (state_reg.ptr == ULDR_OFS_LINE_DRIVER) begin
                state_next.plus_lvl =
                  state_reg.shreg[ULDR_PLUS_MSB:ULDR_PLUS_LSB];
                state_next.minus_lvl =
                  state_reg.shreg[ULDR_MINUS_MSB:ULDR_MINUS_LSB];
              end
              state_next.ptr = state_reg.ptr + 8'h01;
            end
          end
        end
        ULDR_ACK_WR: begin
          if (scl_fall) begin
            state_next.drv = 1'b0;
            state_next.bitcnt = 4'h0;
            state_next.st = ULDR_WRITE;
          end
        end
        ULDR_READ: begin
          if (scl_rise) begin
            state_next.bitcnt = state_reg.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (state_reg.bitcnt == ULDR_BYTE_BITS) begin
              state_next.drv = 1'b0; // release for the controller's ack
              state_next.st = ULDR_ACK_RD;
            end else begin
              state_next.shreg = {state_reg.shreg[6:0], 1'b0};
              state_next.drv = ~state_reg.shreg[6];
            end
          end
        end
        ULDR_ACK_RD: begin
          if (scl_rise && sda_in) begin
            // not acknowledged: stay off the bus until the next start
            state_next.st = ULDR_IDLE;
          end else if (scl_fall) begin
            state_next.bitcnt = 4'h0;
            state_next.shreg = uldr_read(state_reg.ptr, state_reg);
            state_next.drv = ~state_next.shreg[7];
            state_next.ptr = state_reg.ptr + 8'h01;
            state_next.st = ULDR_READ;
            if (state_reg.ptr == ULDR_OFS_MINUS_ADC_HI) begin
              state_next.adc_lo_snap = state_reg.adc[7:0];
            end
          end
        end
        default: begin
          state_next.st = ULDR_IDLE;
          state_next.drv = 1'b0;
        end
      endcase
    end
  end

  // single state register; clock enable low freezes everything
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= '{st: ULDR_IDLE, bitcnt: 4'h0, shreg: 8'h00, ptr: 8'h00,
                     ptr_pending: 1'b0, drv: 1'b0,
                     plus_lvl: ULDR_DRIVE_RST,
                     minus_lvl: ULDR_DRIVE_RST,
                     adc: ULDR_ADC_RST,
                     adc_lo_snap: 8'h00};
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  // open-drain data line: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_out = state_reg.drv;
  // minus code 7 is passed through; the analog driver treats it as reserved
  assign plus_line_drive_level_out = state_reg.plus_lvl;
  assign minus_line_drive_level_out = state_reg.minus_lvl;
  assign minus_line_adc_result_out = state_reg.adc;
endmodule : uldr_line_driver_regs

/* File: logic/uldr_pkg.sv */
// package: register map, field layout and serial-target constants
package uldr_pkg;
  // register offsets on the serial bus
  localparam logic [7:0] ULDR_OFS_MINUS_ADC_HI = 8'h45;
  localparam logic [7:0] ULDR_OFS_MINUS_ADC_LO = 8'h46;
  localparam logic [7:0] ULDR_OFS_LINE_DRIVER = 8'h47;
  localparam logic [7:0] ULDR_OFS_PART_REV = 8'h48;
  // line driver field positions
  localparam int ULDR_PLUS_MSB = 7;
  localparam int ULDR_PLUS_LSB = 5;
  localparam int ULDR_MINUS_MSB = 4;
  localparam int ULDR_MINUS_LSB = 2;
  // identity field positions
  localparam int ULDR_PART_MSB = 5;
  localparam int ULDR_PART_LSB = 3;
  localparam int ULDR_REV_MSB = 2;
  localparam int ULDR_REV_LSB = 0;
  // reset values
  localparam logic [2:0] ULDR_DRIVE_RST = 3'h0;
  localparam logic [15:0] ULDR_ADC_RST = 16'h0000;
  // full scale of the minus-line result, 1 mV per count
  localparam logic [15:0] ULDR_ADC_MAX_MV = 16'h0E10;
  // target address on the serial bus (arbitrary value)
  localparam logic [6:0] ULDR_TARGET_ADDR = 7'h35;
  // part and revision codes (arbitrary values)
  localparam logic [2:0] ULDR_PART_CODE = 3'h2;
  localparam logic [2:0] ULDR_REV_CODE = 3'h5;
  // bits per byte on the serial bus
  localparam logic [3:0] ULDR_BYTE_BITS = 4'h8;
  // protocol states, one-hot
  typedef enum logic [6:0] {
    ULDR_IDLE = 7'h01,
    ULDR_ADDR = 7'h02,
    ULDR_ACK_ADDR = 7'h04,
    ULDR_WRITE = 7'h08,
    ULDR_ACK_WR = 7'h10,
    ULDR_READ = 7'h20,
    ULDR_ACK_RD = 7'h40
  } uldr_state_t;
endpackage : uldr_pkg

/* File: testbench/uldr_line_driver_regs_asserts.sv */
// checker: port-level assertions for the line driver register slice
`timescale 1ns/1ps
module uldr_line_driver_regs_asserts
  import uldr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic adc_valid_in,
  input wire logic [15:0] adc_data_in,
  input wire logic [2:0] plus_line_drive_level_out,
  input wire logic [2:0] minus_line_drive_level_out,
  input wire logic [15:0] minus_line_adc_result_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // an accepted sample, split at full scale
  sequence s_take_low;
    ce_in && adc_valid_in && adc_data_in <= ULDR_ADC_MAX_MV;
  endsequence
  sequence s_take_high;
    ce_in && adc_valid_in && adc_data_in > ULDR_ADC_MAX_MV;
  endsequence
  a_adc_capture_exact: assert property (s_take_low |=>
    minus_line_adc_result_out == $past(adc_data_in))
    else $error("result differs from accepted sample");
  a_adc_clamp_full: assert property (s_take_high |=>
    minus_line_adc_result_out == ULDR_ADC_MAX_MV)
    else $error("result above full scale not clamped");
  a_result_hold_steady: assert property (
    !(ce_in && adc_valid_in) |=> $stable(minus_line_adc_result_out))
    else $error("result moved without a sample");
  // halted clock enable keeps both drive level fields
  a_freeze_when_halted: assert property (!ce_in |=>
    $stable(plus_line_drive_level_out) &&
    $stable(minus_line_drive_level_out))
    else $error("drive level moved while halted");
  // writes land only after a serial clock fall, so scl is low
  a_plus_bus_timing: assert property (
    $changed(plus_line_drive_level_out) |-> !$past(scl_in))
    else $error("plus level changed outside a bus write");
  a_minus_bus_timing: assert property (
    $changed(minus_line_drive_level_out) |-> !$past(scl_in))
    else $error("minus level changed outside a bus write");
endmodule : uldr_line_driver_regs_asserts

bind uldr_line_driver_regs uldr_line_driver_regs_asserts
  uldr_line_driver_regs_asserts_inst (.clk_in, .rstn_in, .ce_in,
  .scl_in, .adc_valid_in, .adc_data_in, .plus_line_drive_level_out,
  .minus_line_drive_level_out, .minus_line_adc_result_out);

/* File: testbench/usb_line_driver_and_id_regs_bench.sv */
// bench: serial-bus tests of the line driver register slice
`timescale 1ns/1ps
`define CHK(g, e) chk(16'(g), 16'(e))
module usb_line_driver_and_id_regs_bench;
  import uldr_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce_in = 1'b1;
  logic scl_in = 1'b1;
  logic sda_drv = 1'b1;
  logic adc_valid_in = 1'b0;
  logic [15:0] adc_data_in = 16'h0000;
  logic sda_out, sda_oe_out, sda_in, a;
  logic [2:0] plus_lvl, minus_lvl;
  logic [15:0] adc_res, pair;
  logic [7:0] d, r, v;
  int n_mismatch = 0;
  int cmp_count = 0;
  int exp_res = 0;
  int samples[$] = '{0, 3600, 3601, 65535};
  // open-drain wire: the device can only pull low
  assign sda_in = sda_drv & ~sda_oe_out;
  always #25 clk_in = ~clk_in;
  uldr_line_driver_regs uldr_line_driver_regs_inst (.clk_in, .rstn_in,
    .ce_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .adc_valid_in,
    .adc_data_in, .plus_line_drive_level_out(plus_lvl),
    .minus_line_drive_level_out(minus_lvl),
    .minus_line_adc_result_out(adc_res));
  task automatic w(input int n);
    repeat (n) @(negedge clk_in);
  endtask : w
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one bit; setup and scl high phases two cycles each, then one cycle after scl falls
  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    w(2);
    scl_in = 1'b1;
    w(2);
    s = sda_in;
    scl_in = 1'b0;
    w(1);
  endtask : bit_io
  task automatic xfer(input logic [7:0] t, input logic l,
                      output logic [7:0] g, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(t[i], g[i]);
    bit_io(l, k);
  endtask : xfer
  task automatic start_c();
    sda_drv = 1'b1;
    w(2);
    scl_in = 1'b1;
    w(2);
    sda_drv = 1'b0;
    w(2);
    scl_in = 1'b0;
    w(2);
  endtask : start_c
  task automatic stop_c();
    sda_drv = 1'b0;
    w(2);
    scl_in = 1'b1;
    w(2);
    sda_drv = 1'b1;
    w(2);
  endtask : stop_c
  task automatic reg_wr(input logic [7:0] o, input logic [7:0] val);
    start_c();
    xfer({ULDR_TARGET_ADDR, 1'b0}, 1'b1, d, a);
    xfer(o, 1'b1, d, a);
    xfer(val, 1'b1, d, a);
    stop_c();
  endtask : reg_wr
  // repeated start keeps the pointer; nack ends the read
  task automatic reg_rd(input logic [7:0] o, output logic [7:0] val);
    start_c();
    xfer({ULDR_TARGET_ADDR, 1'b0}, 1'b1, d, a);
    xfer(o, 1'b1, d, a);
    start_c();
    xfer({ULDR_TARGET_ADDR, 1'b1}, 1'b1, d, a);
    xfer(8'hFF, 1'b1, val, a);
    stop_c();
  endtask : reg_rd
  // two-byte read, acked in between, so both bytes share one snapshot
  task automatic reg_rd2(input logic [7:0] o, output logic [15:0] val);
    start_c();
    xfer({ULDR_TARGET_ADDR, 1'b0}, 1'b1, d, a);
    xfer(o, 1'b1, d, a);
    start_c();
    xfer({ULDR_TARGET_ADDR, 1'b1}, 1'b1, d, a);
    xfer(8'hFF, 1'b0, val[15:8], a);
    xfer(8'hFF, 1'b1, val[7:0], a);
    stop_c();
  endtask : reg_rd2
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    void'($urandom(32'h6814));
    w(6);
    rstn_in = 1'b1;
    w(2);
    `CHK(adc_res, 16'h0000);
    reg_rd(ULDR_OFS_LINE_DRIVER, r);
    `CHK(r, 8'h00);
    `CHK(sda_out, 1'b0);
    reg_rd(ULDR_OFS_PART_REV, r);
    `CHK(r[7:6], 2'h0);
    `CHK(r[5:3], ULDR_PART_CODE);
    `CHK(r[2:0] != 3'h0, 1'b1);
    `CHK(r[2:0], ULDR_REV_CODE);
    reg_wr(ULDR_OFS_PART_REV, 8'($urandom));
    reg_rd(ULDR_OFS_PART_REV, v);
    `CHK(v, r);
    // every plus and minus code, random reserved bits
    for (int k = 0; k < 8; k++) begin
      v = {3'(k), 3'(7 - k), 2'($urandom)};
      reg_wr(ULDR_OFS_LINE_DRIVER, v);
      `CHK(plus_lvl, k);
      `CHK(minus_lvl, 7 - k);
      reg_rd(ULDR_OFS_LINE_DRIVER, r);
      `CHK(r, {v[7:2], 2'h0});
    end
    repeat (4) samples.push_back($urandom_range(5000));
    foreach (samples[i]) begin
      adc_data_in = 16'(samples[i]);
      adc_valid_in = 1'b1;
      w(1);
      adc_valid_in = 1'b0;
      w(1);
      exp_res = samples[i] > 3600 ? 3600 : samples[i];
      `CHK(adc_res, exp_res);
      reg_rd(ULDR_OFS_MINUS_ADC_HI, r);
      reg_rd(ULDR_OFS_MINUS_ADC_LO, d);
      `CHK({r, d}, exp_res);
      reg_rd2(ULDR_OFS_MINUS_ADC_HI, pair);
      `CHK(pair, exp_res);
    end
    // a sample offered while halted is lost
    ce_in = 1'b0;
    adc_data_in = 16'h0123;
    adc_valid_in = 1'b1;
    w(2);
    adc_valid_in = 1'b0;
    ce_in = 1'b1;
    w(1);
    `CHK(adc_res, exp_res);
    // second reset in mid-run clears the drive fields
    rstn_in = 1'b0;
    w(2);
    rstn_in = 1'b1;
    w(2);
    `CHK({plus_lvl, minus_lvl}, 6'h00);
    `CHK(adc_res, 16'h0000);
    tally_and_finish();
  end
  // watchdog: several times the expected run length
  initial begin
    #3ms;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : usb_line_driver_and_id_regs_bench
